// ===== rtl/slow_timer_defines.svh
// constants for the slow-clock pwm timer: register indexes, field positions, reset values
// assumes byte address = 4 * register index on a 32-bit apb bus
`ifndef SLOW_TIMER_DEFINES_SVH
`define SLOW_TIMER_DEFINES_SVH

// ************************************************************
// register indexes
// ************************************************************
`define IDX_SLOW_TIMER_CLOCK_CONTROL 16'h5065
`define IDX_TIMER_CONTROL            16'h50c0
`define IDX_COUNTER_VALUE            16'h50c1
`define IDX_COMPARE_VALUE            16'h50c2
`define IDX_INTERRUPT_MASK           16'h50c3
`define IDX_INTERRUPT_FLAG           16'h50c4
`define IDX_PWM_DUTY_VALUE           16'h50c5

// ************************************************************
// field positions
// ************************************************************
`define BIT_CLOCK_FEED_ENABLE 0
`define LSB_CLOCK_DIVIDE_SEL  1
`define MSB_CLOCK_DIVIDE_SEL  3
`define BIT_RUN_STOP          0
`define BIT_COUNT_MODE        1
`define BIT_COUNTER_CLEAR     4
`define BIT_MATCH_IRQ_ENABLE  0
`define BIT_MATCH_IRQ_FLAG    0

// ************************************************************
// reset values and limits
// ************************************************************
`define RST_CLOCK_DIVIDE_SEL  3'h0
`define RST_COMPARE_VALUE     8'h00
`define RST_BYTE              8'h00
`define MAX_DIVIDE_SEL        3'h5

`endif

// ===== rtl/slow_timer_pkg.sv
// types shared by the slow-clock pwm timer files
// assumes nothing of its surroundings
package slow_timer_pkg;

    // ************************************************************
    // register select
    // ************************************************************
    typedef enum {
        SEL_NONE,
        SEL_CLOCK_CONTROL,
        SEL_TIMER_CONTROL,
        SEL_COUNTER_VALUE,
        SEL_COMPARE_VALUE,
        SEL_INTERRUPT_MASK,
        SEL_INTERRUPT_FLAG,
        SEL_PWM_DUTY_VALUE
    } reg_sel_type;

endpackage

// ===== rtl/magnitude_compare.sv
// equality and greater-than compare of two unsigned words
// assumes purely combinational use
`timescale 1ns/1ps

module magnitude_compare #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    output logic              eq,
    output logic              gt
);

    assign eq = (a == b);
    assign gt = (a > b);

endmodule

// ===== rtl/slow_clock_divider.sv
// divides the slow oscillator tick train by 1..32 and gates it with the feed enable
// assumes osc_tick is a one-cycle pulse per oscillator period, synchronous to mclk
`timescale 1ns/1ps

module slow_clock_divider
    import slow_timer_pkg::*;
#(
    parameter int DW = 5
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic       osc_tick,
    input  wire logic [2:0] clock_divide_select,
    input  wire logic       clock_feed_enable,
    output logic            div_tick
);
`include "slow_timer_defines.svh"

    logic [DW-1:0] pre_q;
    logic [DW-1:0] pre_d;
    logic          tick_q;
    logic          tick_d;
    logic [DW-1:0] limit;

    // ************************************************************
    // prescaler
    // ************************************************************
    always_comb begin
        limit  = DW'((32'h1 << clock_divide_select) - 32'h1);
        pre_d  = pre_q;
        tick_d = 1'b0;
        // reserved codes stop the feed rather than guess a ratio
        if (clock_feed_enable && osc_tick && clock_divide_select <= `MAX_DIVIDE_SEL) begin
            if (pre_q >= limit) begin
                pre_d  = '0;
                tick_d = 1'b1;
            end else begin
                pre_d = pre_q + DW'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pre_q  <= '0;
            tick_q <= 1'b0;
        end else if (clk_en) begin
            pre_q  <= pre_d;
            tick_q <= tick_d;
        end
    end

    assign div_tick = tick_q;

endmodule

// ===== rtl/slow_clock_pwm_timer.sv
// 8-bit up-counting compare/pwm timer on a divided slow oscillator, apb register slave
// assumes apb master on mclk; osc_tick synchronous pulse; irq consumer elsewhere
//
// Behaviour
// - divide select 0..5 gives 1 to 32
// - feed enable gates divided clock, default off
// - writing one to clear bit zeroes counter
// - count equals compare clears counter, signals match
// - compare value resets to zero
// - match period is compare plus one
// - run bit starts, zero halts counting
// - halted counter keeps its value
// - run with clear: clear then count
// - one-shot stops at match, repeat continues
// - match sets interrupt flag bit zero
// - request only when flag and enable set
// - pwm high above duty, low at match
// - duty above compare holds pwm low
// - reserved bits read zero, written zero
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

module slow_clock_pwm_timer
    import slow_timer_pkg::*;
#(
    parameter int AW = 18
) (
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic          clk_en,
    input  wire logic          osc_tick,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    output logic               timer_irq,
    output logic               pwm_output_pin
);
`include "slow_timer_defines.svh"

    // ************************************************************
    // state
    // ************************************************************
    logic [2:0]  div_sel_q;
    logic [2:0]  div_sel_d;
    logic        feed_en_q;
    logic        feed_en_d;
    logic        run_q;
    logic        run_d;
    logic        mode_q;
    logic        mode_d;
    logic [7:0]  cnt_q;
    logic [7:0]  cnt_d;
    logic [7:0]  cmp_q;
    logic [7:0]  cmp_d;
    logic [7:0]  duty_q;
    logic [7:0]  duty_d;
    logic        ie_q;
    logic        ie_d;
    logic        flag_q;
    logic        flag_d;
    logic        pwm_q;
    logic        pwm_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;

    reg_sel_type sel;
    logic        setup;
    logic        access_wr;
    logic        wr_ctl;
    logic        clr_wr;
    logic        div_tick;
    logic        tick;
    logic        cmp_eq;
    logic        duty_gt;
    logic        match;

    // ************************************************************
    // apb decode
    // ************************************************************
    function automatic reg_sel_type decode(input logic [AW-1:0] a);
        reg_sel_type s;
        s = SEL_NONE;
        if (a[1:0] == 2'h0) begin
            case (a[AW-1:2])
                (AW-2)'(`IDX_SLOW_TIMER_CLOCK_CONTROL): s = SEL_CLOCK_CONTROL;
                (AW-2)'(`IDX_TIMER_CONTROL):            s = SEL_TIMER_CONTROL;
                (AW-2)'(`IDX_COUNTER_VALUE):            s = SEL_COUNTER_VALUE;
                (AW-2)'(`IDX_COMPARE_VALUE):            s = SEL_COMPARE_VALUE;
                (AW-2)'(`IDX_INTERRUPT_MASK):           s = SEL_INTERRUPT_MASK;
                (AW-2)'(`IDX_INTERRUPT_FLAG):           s = SEL_INTERRUPT_FLAG;
                (AW-2)'(`IDX_PWM_DUTY_VALUE):           s = SEL_PWM_DUTY_VALUE;
                default:                                s = SEL_NONE;
            endcase
        end
        return s;
    endfunction

    assign sel       = decode(paddr);
    assign setup     = psel && !penable;
    // read data is latched in setup, so access completes in its first cycle with clk_en high
    assign pready    = psel && penable && clk_en;
    assign pslverr   = pready && (sel == SEL_NONE);
    assign access_wr = pready && pwrite;
    assign wr_ctl    = access_wr && (sel == SEL_TIMER_CONTROL);
    assign clr_wr    = wr_ctl && pwdata[`BIT_COUNTER_CLEAR];
    assign prdata    = {24'h000000, rdata_q};

    // ************************************************************
    // count clock and comparators
    // ************************************************************
    // prescaler phase runs on while halted, so a restart may gain one tick
    slow_clock_divider #(
        .DW (5)
    ) u_divider (
        .mclk                (mclk),
        .rst_n               (rst_n),
        .clk_en              (clk_en),
        .osc_tick            (osc_tick),
        .clock_divide_select (div_sel_q),
        .clock_feed_enable   (feed_en_q),
        .div_tick            (div_tick)
    );

    magnitude_compare #(
        .W (8)
    ) u_cmp_match (
        .a  (cnt_q),
        .b  (cmp_q),
        .eq (cmp_eq),
        .gt ()
    );

    magnitude_compare #(
        .W (8)
    ) u_cmp_duty (
        .a  (cnt_d),
        .b  (duty_q),
        .eq (),
        .gt (duty_gt)
    );

    assign tick  = div_tick && run_q;
    // a clear in the same cycle wins over the match
    assign match = tick && cmp_eq && !clr_wr;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        div_sel_d = div_sel_q;
        feed_en_d = feed_en_q;
        run_d     = run_q;
        mode_d    = mode_q;
        cnt_d     = cnt_q;
        cmp_d     = cmp_q;
        duty_d    = duty_q;
        ie_d      = ie_q;
        flag_d    = flag_q;
        rdata_d   = rdata_q;

        if (access_wr) begin
            case (sel)
                SEL_CLOCK_CONTROL: begin
                    div_sel_d = pwdata[`MSB_CLOCK_DIVIDE_SEL:`LSB_CLOCK_DIVIDE_SEL];
                    feed_en_d = pwdata[`BIT_CLOCK_FEED_ENABLE];
                end
                SEL_TIMER_CONTROL: begin
                    mode_d = pwdata[`BIT_COUNT_MODE];
                end
                SEL_COMPARE_VALUE:  cmp_d  = pwdata[7:0];
                SEL_INTERRUPT_MASK: ie_d   = pwdata[`BIT_MATCH_IRQ_ENABLE];
                SEL_PWM_DUTY_VALUE: duty_d = pwdata[7:0];
                default: ;
            endcase
        end

        // counter
        // limitation: compare lowered below the count waits for the wrap
        if (clr_wr) begin
            cnt_d = 8'h00;
        end else if (match) begin
            cnt_d = 8'h00;
        end else if (tick) begin
            cnt_d = cnt_q + 8'h01;
        end

        // run bit: software write beats the one-shot stop
        if (wr_ctl) begin
            run_d = pwdata[`BIT_RUN_STOP];
        end else if (match && mode_q) begin
            run_d = 1'b0;
        end

        // flag: set wins over a write-one clear
        if (match) begin
            flag_d = 1'b1;
        end else if (access_wr && sel == SEL_INTERRUPT_FLAG && pwdata[`BIT_MATCH_IRQ_FLAG]) begin
            flag_d = 1'b0;
        end

        // pwm: compare bound keeps duty above compare low
        // duty is tested on the next count so pin and counter move together
        pwm_d = duty_gt && (duty_q < cmp_q);

        if (setup) begin
            case (sel)
                SEL_CLOCK_CONTROL:  rdata_d = {4'h0, div_sel_q, feed_en_q};
                SEL_TIMER_CONTROL:  rdata_d = {6'h00, mode_q, run_q};
                SEL_COUNTER_VALUE:  rdata_d = cnt_q;
                SEL_COMPARE_VALUE:  rdata_d = cmp_q;
                SEL_INTERRUPT_MASK: rdata_d = {7'h00, ie_q};
                SEL_INTERRUPT_FLAG: rdata_d = {7'h00, flag_q};
                SEL_PWM_DUTY_VALUE: rdata_d = duty_q;
                default:            rdata_d = 8'h00;
            endcase
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            div_sel_q <= `RST_CLOCK_DIVIDE_SEL;
            feed_en_q <= 1'b0;
            run_q     <= 1'b0;
            mode_q    <= 1'b0;
            cnt_q     <= `RST_BYTE;
            cmp_q     <= `RST_COMPARE_VALUE;
            duty_q    <= `RST_BYTE;
            ie_q      <= 1'b0;
            flag_q    <= 1'b0;
            pwm_q     <= 1'b0;
            rdata_q   <= `RST_BYTE;
        end else if (clk_en) begin
            div_sel_q <= div_sel_d;
            feed_en_q <= feed_en_d;
            run_q     <= run_d;
            mode_q    <= mode_d;
            cnt_q     <= cnt_d;
            cmp_q     <= cmp_d;
            duty_q    <= duty_d;
            ie_q      <= ie_d;
            flag_q    <= flag_d;
            pwm_q     <= pwm_d;
            rdata_q   <= rdata_d;
        end
    end

    assign timer_irq      = flag_q && ie_q;
    assign pwm_output_pin = pwm_q;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_MATCH_CLEARS: assert property (clk_en && match |=> cnt_q == 8'h00)
        else $error("counter not cleared on compare match");

    AST_MATCH_FLAG: assert property (clk_en && match |=> flag_q)
        else $error("match did not set the flag");

    AST_IRQ_GATE: assert property (clk_en && match && ie_q && !(access_wr && sel == SEL_INTERRUPT_MASK)
                                   |=> timer_irq)
        else $error("enabled match raised no request");

    AST_HALT_HOLDS: assert property (!run_q && !clr_wr |=> cnt_q == $past(cnt_q))
        else $error("halted counter changed");

    AST_CLEAR_WRITE: assert property (clr_wr |=> cnt_q == 8'h00)
        else $error("clear write left counter nonzero");

    AST_RUN_AND_CLEAR: assert property (clr_wr && pwdata[`BIT_RUN_STOP] |=> cnt_q == 8'h00 && run_q)
        else $error("run with clear misbehaved");

    AST_ONESHOT_STOP: assert property (clk_en && match && mode_q && !wr_ctl |=> !run_q)
        else $error("one-shot kept running after match");

    AST_REPEAT_RUNS: assert property (clk_en && match && !mode_q && !wr_ctl |=> run_q)
        else $error("repeat mode stopped at match");

    AST_INCREMENT: assert property (clk_en && tick && !cmp_eq && !clr_wr |=> cnt_q == $past(cnt_q) + 8'h01)
        else $error("counter did not step by one");

    AST_PWM_LOW: assert property (clk_en && duty_q > cmp_q && !access_wr |=> !pwm_q)
        else $error("pwm high with duty above compare");

    AST_RSVD_READ: assert property (setup && !pwrite && sel == SEL_TIMER_CONTROL && clk_en
                                    |=> prdata[31:2] == 30'h0)
        else $error("reserved control bits read nonzero");

    COV_REPEAT_MATCH: cover property (match && !mode_q);
    COV_ONESHOT_STOP: cover property (match && mode_q ##1 !run_q);
    COV_PWM_RISE: cover property (!pwm_q ##1 pwm_q);
    // register and tick checks, all one edge after the cause
    AST_RESERVED_DIV: assert property (clk_en && div_sel_q > `MAX_DIVIDE_SEL |=> !div_tick)
        else $error("reserved divide code produced a count tick");

    AST_FEED_OFF: assert property (clk_en && !feed_en_q |=> !div_tick)
        else $error("count tick with clock feed off");

    AST_RUN_WRITE: assert property (wr_ctl |=> run_q == $past(pwdata[`BIT_RUN_STOP]))
        else $error("run bit did not follow the control write");

    AST_MODE_WRITE: assert property (wr_ctl |=> mode_q == $past(pwdata[`BIT_COUNT_MODE]))
        else $error("mode bit did not follow the control write");

    AST_CMP_WRITE: assert property (access_wr && sel == SEL_COMPARE_VALUE |=> cmp_q == 8'($past(pwdata)))
        else $error("compare value not stored");

    AST_FLAG_CLEAR: assert property (!match && access_wr && sel == SEL_INTERRUPT_FLAG
                                     && pwdata[`BIT_MATCH_IRQ_FLAG] |=> !flag_q)
        else $error("write one did not clear the flag");

    AST_FLAG_HOLDS: assert property (clk_en && !match && !(access_wr && sel == SEL_INTERRUPT_FLAG)
                                     |=> flag_q == $past(flag_q))
        else $error("flag changed without match or clear");

    AST_PWM_RISE: assert property (clk_en && tick && !clr_wr && cnt_q == duty_q && duty_q < cmp_q |=> pwm_q)
        else $error("pwm did not rise past duty");

    AST_PWM_DROP: assert property (clk_en && match |=> !pwm_q)
        else $error("pwm not low after compare match");

    AST_FREEZE: assert property (!clk_en |=> cnt_q == $past(cnt_q) && flag_q == $past(flag_q))
        else $error("state moved with clock enable low");

    COV_IRQ: cover property (timer_irq);
    COV_CLEAR_RUN: cover property (clr_wr && pwdata[`BIT_RUN_STOP]);

endmodule

// ===== verif/slow_osc_model.sv
// partner model: slow oscillator tick source in front of the timer
// assumes mclk is the bus clock; one tick pulse every GAP cycles
`timescale 1ns/1ps

module slow_osc_model #(
    parameter int GAP = 4
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    output logic      osc_tick
);
    // ********************
    // tick train
    // ********************
    // free running like the real oscillator; reset only restarts phase
    int   ph_q;
    int   ph_d;
    logic tick_d;

    always_comb begin
        ph_d   = (ph_q == GAP - 1) ? 0 : ph_q + 1;
        tick_d = (ph_q == GAP - 1);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ph_q     <= 0;
            osc_tick <= 1'b0;
        end else begin
            ph_q     <= ph_d;
            osc_tick <= tick_d;
        end
    end
endmodule

// ===== verif/slow_clock_pwm_timer_tb_top.sv
// self-checking bench for the slow-clock pwm timer over apb
// assumes the oscillator model as tick source; clk_en dropped once to check freezing
`timescale 1ns/1ps
`include "slow_timer_defines.svh"

module slow_clock_pwm_timer_tb_top
    import slow_timer_pkg::*;
;
    localparam int          GAP   = 4;
    localparam logic [15:0] r_clk = `IDX_SLOW_TIMER_CLOCK_CONTROL;
    localparam logic [15:0] r_ctl = `IDX_TIMER_CONTROL;
    localparam logic [15:0] r_cnt = `IDX_COUNTER_VALUE;
    localparam logic [15:0] r_cmp = `IDX_COMPARE_VALUE;
    localparam logic [15:0] r_msk = `IDX_INTERRUPT_MASK;
    localparam logic [15:0] r_flg = `IDX_INTERRUPT_FLAG;
    localparam logic [15:0] r_dty = `IDX_PWM_DUTY_VALUE;
    localparam logic [15:0] tab [7] = '{r_clk, r_ctl, r_cnt, r_cmp, r_msk, r_flg, r_dty};
    localparam logic [15:0] pw [3]  = '{16'h0301, 16'h0305, 16'h0100};
    localparam int          pw_hi [3] = '{32, 0, 32};

    logic        mclk    = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic        clk_en  = 1'b1;
    logic [17:0] paddr   = 18'h0;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        timer_irq;
    logic        pwm_output_pin;
    logic        osc_tick;
    logic [31:0] rd;
    logic [31:0] c1;
    logic [31:0] c2;
    logic        er;
    int          err_total  = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          t1;
    int          hi;
    int          k;

    always #5 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;

    slow_osc_model #(.GAP(GAP)) u_slow_osc_model (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .osc_tick (osc_tick)
    );

    slow_clock_pwm_timer u_slow_clock_pwm_timer (
        .mclk           (mclk),
        .rst_n          (rst_n),
        .clk_en         (clk_en),
        .osc_tick       (osc_tick),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .timer_irq      (timer_irq),
        .pwm_output_pin (pwm_output_pin)
    );

    // ********************
    // checking and closing
    // ********************
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        err_total++;
        $display("ERROR at %0t: %s", $time, msg);
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) fail($sformatf("value %h, expected %h", got, exp));
    endtask

    task automatic chk_num(input int got, input int exp);
        n_compared++;
        if (got != exp) fail($sformatf("count %0d, expected %0d", got, exp));
    endtask

    // ********************
    // apb master
    // ********************
    // request held until pready is sampled high; no wait count assumed
    task automatic apb(input logic wr_en, input logic [15:0] idx, input logic [7:0] d);
        int n;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            fail("no pready");
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk_reg(rd, {24'h0, exp});
    endtask

    task automatic wait_irq(input int lim);
        int n;
        for (n = 0; n < lim; n++) begin
            @(posedge mclk);
            if (timer_irq === 1'b1) break;
        end
        if (n == lim) begin
            fail("no interrupt");
            print_verdict();
        end
    endtask

    // ********************
    // scenarios
    // ********************
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (tab[i]) rdchk(tab[i], 8'h00);
        apb(1'b0, 16'h50c6, 8'h00);
        chk_reg({31'h0, er}, 32'h1);
        wr(r_cnt, 8'h55);
        rdchk(r_cnt, 8'h00);
        wr(r_ctl, 8'hec);
        rdchk(r_ctl, 8'h00);
        wr(r_msk, 8'hfe);
        rdchk(r_msk, 8'h00);
        $display("test registers done");
        wr(r_cmp, 8'hff);
        wr(r_clk, 8'h01);
        wr(r_ctl, 8'h11);
        repeat (40) @(posedge mclk);
        wr(r_ctl, 8'h00);
        apb(1'b0, r_cnt, 8'h00);
        c1 = rd;
        chk_reg({31'h0, c1 inside {32'd10, 32'd11}}, 32'h1);
        repeat (50) @(posedge mclk);
        rdchk(r_cnt, c1[7:0]);
        wr(r_ctl, 8'h01);
        repeat (40) @(posedge mclk);
        wr(r_ctl, 8'h00);
        apb(1'b0, r_cnt, 8'h00);
        c2 = rd - c1;
        chk_reg({31'h0, c2 inside {32'd10, 32'd11}}, 32'h1);
        wr(r_ctl, 8'h11);
        clk_en <= 1'b0;
        repeat (40) @(posedge mclk);
        clk_en <= 1'b1;
        wr(r_ctl, 8'h00);
        apb(1'b0, r_cnt, 8'h00);
        chk_reg({31'h0, rd inside {32'd0, 32'd1}}, 32'h1);
        wr(r_ctl, 8'h10);
        rdchk(r_cnt, 8'h00);
        rdchk(r_ctl, 8'h00);
        wr(r_ctl, 8'h01);
        repeat (40) @(posedge mclk);
        wr(r_ctl, 8'h00);
        wr(r_clk, 8'h00);
        wr(r_ctl, 8'h11);
        repeat (60) @(posedge mclk);
        wr(r_ctl, 8'h00);
        rdchk(r_cnt, 8'h00);
        $display("test counting done");
        wr(r_cmp, 8'h03);
        wr(r_clk, 8'h01);
        wr(r_ctl, 8'h11);
        repeat (40) @(posedge mclk);
        chk_reg({31'h0, timer_irq}, 32'h0);
        rdchk(r_flg, 8'h01);
        wr(r_flg, 8'h00);
        rdchk(r_flg, 8'h01);
        wr(r_msk, 8'h01);
        @(negedge mclk);
        chk_reg({31'h0, timer_irq}, 32'h1);
        wr(r_ctl, 8'h00);
        wr(r_flg, 8'h01);
        @(negedge mclk);
        chk_reg({31'h0, timer_irq}, 32'h0);
        for (k = 0; k < 8; k++) begin
            wr(r_ctl, 8'h00);
            wr(r_clk, {4'h0, k[2:0], 1'b1});
            wr(r_flg, 8'h01);
            wr(r_ctl, 8'h11);
            if (k >= 6) begin
                repeat (300) @(posedge mclk);
                rdchk(r_cnt, 8'h00);
            end else begin
                wait_irq(1200);
                t1 = cyc;
                wr(r_flg, 8'h01);
                wait_irq(1200);
                chk_num(cyc - t1, (4 * GAP) << k);
            end
        end
        $display("test match period done");
        wr(r_ctl, 8'h00);
        wr(r_clk, 8'h01);
        wr(r_flg, 8'h01);
        wr(r_ctl, 8'h13);
        wait_irq(300);
        repeat (40) @(posedge mclk);
        rdchk(r_ctl, 8'h02);
        rdchk(r_cnt, 8'h00);
        $display("test one-shot done");
        for (k = 0; k < 3; k++) begin
            wr(r_ctl, 8'h00);
            wr(r_cmp, pw[k][15:8]);
            wr(r_dty, pw[k][7:0]);
            wr(r_ctl, 8'h11);
            repeat (20) @(posedge mclk);
            hi = 0;
            repeat (64) begin
                @(posedge mclk);
                if (pwm_output_pin === 1'b1) hi++;
            end
            chk_num(hi, pw_hi[k]);
        end
        $display("test pwm done");
        print_verdict();
    end
endmodule
